/* File: logic/fpsq_ctrl.sv */
// flash program and erase controller with its axi4-lite register slave
// What this block does
// - program is three unlock writes then address and data write
// - on failure bit, re-read toggle; still busy means error and reset
// - after success do one more read of the data
// - bulk erase is six coded writes; a wrong one aborts it
// - more sectors added by single confirm writes restart the time-out
// - suspend is one b0h write anywhere, only during sector erase; this block sends it whenever commanded while idle
// - resume is one 30h write anywhere and continues the erase
`timescale 1ns/100ps
`include "fpsq_regs.svh"
module fpsq_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] dq_i,
    output fpsq_pkg::fpsq_pins_type pins
);
    typedef enum logic [2:0] {
        SQ_IDLE, SQ_WR, SQ_RD1, SQ_RD2, SQ_RD3, SQ_FIN, SQ_RST, SQ_SUSP
    } sq_type;

    // axi slave state
    logic aw_v_r, aw_v_nxt, w_v_r, w_v_nxt, bvalid_r, bvalid_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [7:0] aw_a_r, aw_a_nxt;
    logic [31:0] w_d_r, w_d_nxt, rd_r, rd_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic wr_fire;
    // sequencer state
    sq_type st_r, st_nxt;
    fpsq_pkg::fpsq_cmd_type cmd_r, cmd_nxt;
    fpsq_pkg::fpsq_cyc_type req_r, req_nxt;
    logic [18:0] addr_r, addr_nxt;
    logic [7:0] data_r, data_nxt, prev_r, prev_nxt, last_r, last_nxt;
    logic [2:0] step_r, step_nxt;
    logic [11:0] cnt_r, cnt_nxt;
    logic start_r, start_nxt, done_r, done_nxt, fail_r, fail_nxt;
    logic win_r, win_nxt;
    logic cyc_done;
    logic [7:0] cyc_rd;
    logic [31:0] status;

    function automatic logic [2:0] n_writes(fpsq_pkg::fpsq_cmd_type c);
        case (c)
            fpsq_pkg::CMD_PROG: n_writes = 3'd4;
            fpsq_pkg::CMD_BULK, fpsq_pkg::CMD_SECT: n_writes = 3'd6;
            fpsq_pkg::CMD_READ, fpsq_pkg::CMD_POLL: n_writes = 3'd0;
            default: n_writes = 3'd1;
        endcase
    endfunction

    function automatic fpsq_pkg::fpsq_cyc_type step_cyc(
        fpsq_pkg::fpsq_cmd_type c, logic [2:0] s, logic [18:0] a,
        logic [7:0] d);
        logic prog;
        prog = (c == fpsq_pkg::CMD_PROG);
        case (s)
            3'd0: step_cyc = {1'b1, `FPSQ_UNLK_ADDR1, `FPSQ_UNLK_DATA1};
            3'd1: step_cyc = {1'b1, `FPSQ_UNLK_ADDR2, `FPSQ_UNLK_DATA2};
            3'd2: step_cyc = {1'b1, `FPSQ_UNLK_ADDR1,
                prog ? `FPSQ_PROG_CODE : `FPSQ_ERASE_SETUP};
            3'd3: step_cyc = prog ? {1'b1, a, d}
                : {1'b1, `FPSQ_UNLK_ADDR1, `FPSQ_UNLK_DATA1};
            3'd4: step_cyc = {1'b1, `FPSQ_UNLK_ADDR2, `FPSQ_UNLK_DATA2};
            default: step_cyc = (c == fpsq_pkg::CMD_BULK)
                ? {1'b1, `FPSQ_UNLK_ADDR1, `FPSQ_BULK_CONFIRM}
                : {1'b1, a, `FPSQ_SECT_CONFIRM};
        endcase
        // single-write instructions go to the user address
        case (c)
            fpsq_pkg::CMD_SECT_ADD: step_cyc = {1'b1, a, `FPSQ_SECT_CONFIRM};
            fpsq_pkg::CMD_SUSP: step_cyc = {1'b1, a, `FPSQ_SUSPEND_CODE};
            fpsq_pkg::CMD_RESUME: step_cyc = {1'b1, a, `FPSQ_RESUME_CODE};
            fpsq_pkg::CMD_RESET: step_cyc = {1'b1, a, `FPSQ_RESET_CODE};
            default: ;
        endcase
    endfunction

    assign wr_fire = aw_v_r && w_v_r && !bvalid_r;
    assign status = {28'h0000000, win_r, fail_r, done_r, st_r != SQ_IDLE};

    always_comb begin
        aw_v_nxt = aw_v_r;
        aw_a_nxt = aw_a_r;
        w_v_nxt = w_v_r;
        w_d_nxt = w_d_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rd_nxt = rd_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_v_nxt = 1'b1;
            aw_a_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_v_nxt = 1'b1;
            w_d_nxt = s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready)
            bvalid_nxt = 1'b0;
        if (wr_fire) begin
            aw_v_nxt = 1'b0;
            w_v_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (aw_a_r <= `FPSQ_OFS_WDATA && aw_a_r[1:0] == 2'b00)
                ? `FPSQ_RESP_OKAY : `FPSQ_RESP_DECERR;
        end
        if (s_axi_rvalid && s_axi_rready)
            rvalid_nxt = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `FPSQ_RESP_OKAY;
            case (s_axi_araddr)
                `FPSQ_OFS_CMD: rd_nxt = {28'h0000000, cmd_r};
                `FPSQ_OFS_ADDR: rd_nxt = {13'h0000, addr_r};
                `FPSQ_OFS_WDATA: rd_nxt = {24'h000000, data_r};
                `FPSQ_OFS_STATUS: rd_nxt = status;
                `FPSQ_OFS_RDATA: rd_nxt = {24'h000000, last_r};
                default: begin
                    rd_nxt = 32'h00000000;
                    rresp_nxt = `FPSQ_RESP_DECERR;
                end
            endcase
        end
    end

    always_comb begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        req_nxt = req_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        prev_nxt = prev_r;
        last_nxt = last_r;
        step_nxt = step_r;
        cnt_nxt = cnt_r;
        start_nxt = 1'b0;
        done_nxt = done_r;
        fail_nxt = fail_r;
        win_nxt = win_r;
        if (wr_fire && aw_a_r == `FPSQ_OFS_ADDR)
            addr_nxt = w_d_r[18:0];
        if (wr_fire && aw_a_r == `FPSQ_OFS_WDATA)
            data_nxt = w_d_r[7:0];
        case (st_r)
            // a command written while busy is dropped; status shows busy
            SQ_IDLE: if (wr_fire && aw_a_r == `FPSQ_OFS_CMD) begin
                cmd_nxt = fpsq_pkg::fpsq_cmd_type'(w_d_r[3:0]);
                done_nxt = 1'b0;
                fail_nxt = 1'b0;
                step_nxt = 3'd0;
                start_nxt = 1'b1;
                if (n_writes(cmd_nxt) != 3'd0) begin
                    req_nxt = step_cyc(cmd_nxt, 3'd0, addr_r, data_r);
                    st_nxt = SQ_WR;
                end else begin
                    req_nxt = {1'b0, addr_r, 8'h00};
                    st_nxt = (cmd_nxt == fpsq_pkg::CMD_READ) ? SQ_FIN : SQ_RD1;
                end
            end
            SQ_WR: if (cyc_done) begin
                if (step_r + 3'd1 < n_writes(cmd_r)) begin
                    step_nxt = step_r + 3'd1;
                    req_nxt = step_cyc(cmd_r, step_nxt, addr_r, data_r);
                    start_nxt = 1'b1;
                end else if (cmd_r == fpsq_pkg::CMD_PROG
                        || cmd_r == fpsq_pkg::CMD_BULK) begin
                    req_nxt = {1'b0, addr_r, 8'h00};
                    start_nxt = 1'b1;
                    st_nxt = SQ_RD1;
                end else if (cmd_r == fpsq_pkg::CMD_SUSP) begin
                    cnt_nxt = 12'(`FPSQ_SUSP_CYC);
                    st_nxt = SQ_SUSP;
                end else begin
                    // sector adds return at once so the next lands in time
                    done_nxt = 1'b1;
                    st_nxt = SQ_IDLE;
                end
            end
            SQ_RD1: if (cyc_done) begin
                prev_nxt = cyc_rd;
                start_nxt = 1'b1;
                st_nxt = SQ_RD2;
            end
            SQ_RD2: if (cyc_done) begin
                win_nxt = cyc_rd[`FPSQ_WINDOW_BIT];
                prev_nxt = cyc_rd;
                start_nxt = 1'b1;
                if (cyc_rd[`FPSQ_TOGGLE_BIT] == prev_r[`FPSQ_TOGGLE_BIT])
                    st_nxt = SQ_FIN;
                else if (cyc_rd[`FPSQ_FAIL_BIT])
                    st_nxt = SQ_RD3;
            end
            SQ_RD3: if (cyc_done) begin
                start_nxt = 1'b1;
                if (cyc_rd[`FPSQ_TOGGLE_BIT] == prev_r[`FPSQ_TOGGLE_BIT]) begin
                    st_nxt = SQ_FIN;
                end else begin
                    fail_nxt = 1'b1;
                    req_nxt = {1'b1, addr_r, `FPSQ_RESET_CODE};
                    st_nxt = SQ_RST;
                end
            end
            SQ_FIN: if (cyc_done) begin
                last_nxt = cyc_rd;
                done_nxt = 1'b1;
                st_nxt = SQ_IDLE;
            end
            SQ_RST: if (cyc_done) begin
                done_nxt = 1'b1;
                st_nxt = SQ_IDLE;
            end
            SQ_SUSP: begin
                // wait out the longest stop time before reading the array
                cnt_nxt = cnt_r - 12'h001;
                if (cnt_r == 12'h001) begin
                    done_nxt = 1'b1;
                    st_nxt = SQ_IDLE;
                end
            end
            default: st_nxt = SQ_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_r <= 1'b0;
            aw_a_r <= 8'h00;
            w_v_r <= 1'b0;
            w_d_r <= 32'h00000000;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rd_r <= 32'h00000000;
            rresp_r <= 2'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            aw_v_r <= aw_v_nxt;
            aw_a_r <= aw_a_nxt;
            w_v_r <= w_v_nxt;
            w_d_r <= w_d_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rd_r <= rd_nxt;
            rresp_r <= rresp_nxt;
            s_axi_awready <= !aw_v_nxt;
            s_axi_wready <= !w_v_nxt;
            s_axi_arready <= !rvalid_nxt && !s_axi_arready;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= SQ_IDLE;
            cmd_r <= fpsq_pkg::CMD_READ;
            req_r <= '0;
            addr_r <= 19'h00000;
            data_r <= 8'h00;
            prev_r <= 8'h00;
            last_r <= 8'h00;
            step_r <= 3'd0;
            cnt_r <= 12'h000;
            start_r <= 1'b0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            win_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            req_r <= req_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            prev_r <= prev_nxt;
            last_r <= last_nxt;
            step_r <= step_nxt;
            cnt_r <= cnt_nxt;
            start_r <= start_nxt;
            done_r <= done_nxt;
            fail_r <= fail_nxt;
            win_r <= win_nxt;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rd_r;
    assign s_axi_rresp = rresp_r;

    fpsq_cycle u_cycle (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start_r),
        .req(req_r),
        .dq_i(dq_i),
        .pins(pins),
        .done(cyc_done),
        .rdata(cyc_rd)
    );

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    prog_data_write_a: assert property (
        st_r == SQ_WR && cmd_r == fpsq_pkg::CMD_PROG && step_r == 3'd3
        |-> req_r == {1'b1, addr_r, data_r})
        else $error("program fourth write wrong");
    fail_reset_a: assert property (
        st_r == SQ_RD3 && cyc_done
        && cyc_rd[`FPSQ_TOGGLE_BIT] != prev_r[`FPSQ_TOGGLE_BIT]
        |=> st_r == SQ_RST && start_r && fail_r
        && req_r.data == `FPSQ_RESET_CODE)
        else $error("failed poll did not reset device");
    final_read_a: assert property (
        st_r == SQ_RD2 && cyc_done
        && cyc_rd[`FPSQ_TOGGLE_BIT] == prev_r[`FPSQ_TOGGLE_BIT]
        |=> st_r == SQ_FIN && start_r && !req_r.wr)
        else $error("no confirming read after success");
    bulk_confirm_a: assert property (
        st_r == SQ_WR && cmd_r == fpsq_pkg::CMD_BULK && step_r == 3'd5
        |-> req_r == {1'b1, `FPSQ_UNLK_ADDR1, `FPSQ_BULK_CONFIRM})
        else $error("bulk erase sixth write wrong");
    sector_add_a: assert property (
        st_r == SQ_WR && cmd_r == fpsq_pkg::CMD_SECT_ADD && cyc_done
        |-> req_r == {1'b1, addr_r, `FPSQ_SECT_CONFIRM}
        ##1 st_r == SQ_IDLE && done_r)
        else $error("sector add not single confirm write");
    suspend_wait_a: assert property (
        st_r == SQ_WR && cmd_r == fpsq_pkg::CMD_SUSP && cyc_done
        |-> req_r.data == `FPSQ_SUSPEND_CODE
        ##1 st_r == SQ_SUSP && cnt_r == 12'(`FPSQ_SUSP_CYC))
        else $error("suspend write or wait wrong");
    resume_code_a: assert property (
        st_r == SQ_WR && cmd_r == fpsq_pkg::CMD_RESUME
        |-> req_r == {1'b1, addr_r, `FPSQ_RESUME_CODE})
        else $error("resume write wrong");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
endmodule // fpsq_ctrl

/* File: logic/fpsq_cycle.sv */
// one timed write or read cycle on the parallel memory pins
`timescale 1ns/100ps
`include "fpsq_regs.svh"
module fpsq_cycle (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire fpsq_pkg::fpsq_cyc_type req,
    input wire logic [7:0] dq_i,
    output fpsq_pkg::fpsq_pins_type pins,
    output logic done,
    output logic [7:0] rdata
);
    typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD} cy_type;
    cy_type st_r, st_nxt;
    fpsq_pkg::fpsq_pins_type pins_r, pins_nxt;
    logic [7:0] cnt_r, cnt_nxt, rdata_r, rdata_nxt;
    logic done_r, done_nxt, wr_r, wr_nxt;

    always_comb begin
        st_nxt = st_r;
        pins_nxt = pins_r;
        cnt_nxt = cnt_r;
        rdata_nxt = rdata_r;
        wr_nxt = wr_r;
        done_nxt = 1'b0;
        case (st_r)
            CY_IDLE: if (start) begin
                pins_nxt.addr = req.addr;
                pins_nxt.en_n = 1'b0;
                wr_nxt = req.wr;
                if (req.wr) begin
                    pins_nxt.dq_o = req.data;
                    pins_nxt.dq_oe = 1'b1;
                    st_nxt = CY_SETUP;
                end else begin
                    pins_nxt.oe_n = 1'b0;
                    cnt_nxt = 8'(`FPSQ_ACC_CYC);
                    st_nxt = CY_PULSE;
                end
            end
            CY_SETUP: begin
                pins_nxt.we_n = 1'b0;
                cnt_nxt = 8'(`FPSQ_WP_CYC);
                st_nxt = CY_PULSE;
            end
            CY_PULSE: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    // data is latched by the device on the rising write edge
                    pins_nxt.we_n = 1'b1;
                    pins_nxt.oe_n = 1'b1;
                    if (!wr_r)
                        rdata_nxt = dq_i;
                    cnt_nxt = 8'(`FPSQ_WPH_CYC);
                    st_nxt = CY_HOLD;
                end
            end
            CY_HOLD: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    pins_nxt.en_n = 1'b1;
                    pins_nxt.dq_oe = 1'b0;
                    done_nxt = 1'b1;
                    st_nxt = CY_IDLE;
                end
            end
            default: st_nxt = CY_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= CY_IDLE;
            pins_r <= '{en_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
            cnt_r <= 8'h00;
            rdata_r <= 8'h00;
            wr_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pins_r <= pins_nxt;
            cnt_r <= cnt_nxt;
            rdata_r <= rdata_nxt;
            wr_r <= wr_nxt;
            done_r <= done_nxt;
        end
    end

    assign pins = pins_r;
    assign done = done_r;
    assign rdata = rdata_r;
endmodule // fpsq_cycle

/* File: logic/fpsq_pkg.sv */
// types shared by the flash sequencer controller
package fpsq_pkg;
    typedef enum logic [3:0] {
        CMD_READ, CMD_PROG, CMD_BULK, CMD_SECT, CMD_SECT_ADD,
        CMD_SUSP, CMD_RESUME, CMD_RESET, CMD_POLL
    } fpsq_cmd_type;
    typedef struct packed {
        logic wr;
        logic [18:0] addr;
        logic [7:0] data;
    } fpsq_cyc_type;
    typedef struct packed {
        logic en_n;
        logic oe_n;
        logic we_n;
        logic [18:0] addr;
        logic [7:0] dq_o;
        logic dq_oe;
    } fpsq_pins_type;
endpackage

/* File: logic/fpsq_regs.svh */
// offsets, field positions, codes and timing counts of the flash sequencer
`ifndef FPSQ_REGS_SVH
`define FPSQ_REGS_SVH
`define FPSQ_CLK_NS 4
`define FPSQ_CYC_UP(ns) (((ns) + `FPSQ_CLK_NS - 1) / `FPSQ_CLK_NS)
`define FPSQ_T_WP_NS 50
`define FPSQ_T_WPH_NS 30
`define FPSQ_T_ACC_NS 120
`define FPSQ_T_SUSP_NS 15000
`define FPSQ_WP_CYC `FPSQ_CYC_UP(`FPSQ_T_WP_NS)
`define FPSQ_WPH_CYC `FPSQ_CYC_UP(`FPSQ_T_WPH_NS)
`define FPSQ_ACC_CYC `FPSQ_CYC_UP(`FPSQ_T_ACC_NS)
`define FPSQ_SUSP_CYC `FPSQ_CYC_UP(`FPSQ_T_SUSP_NS)
`define FPSQ_OFS_CMD 8'h00
`define FPSQ_OFS_ADDR 8'h04
`define FPSQ_OFS_WDATA 8'h08
`define FPSQ_OFS_STATUS 8'h0c
`define FPSQ_OFS_RDATA 8'h10
`define FPSQ_STS_BUSY 0
`define FPSQ_STS_DONE 1
`define FPSQ_STS_FAIL 2
`define FPSQ_STS_WINDOW 3
`define FPSQ_POLL_BIT 7
`define FPSQ_TOGGLE_BIT 6
`define FPSQ_FAIL_BIT 5
`define FPSQ_WINDOW_BIT 3
`define FPSQ_UNLK_ADDR1 19'h05555
`define FPSQ_UNLK_ADDR2 19'h02aaa
`define FPSQ_UNLK_DATA1 8'haa
`define FPSQ_UNLK_DATA2 8'h55
`define FPSQ_PROG_CODE 8'ha0
`define FPSQ_ERASE_SETUP 8'h80
`define FPSQ_BULK_CONFIRM 8'h10
`define FPSQ_SECT_CONFIRM 8'h30
`define FPSQ_SUSPEND_CODE 8'hb0
`define FPSQ_RESUME_CODE 8'h30
`define FPSQ_RESET_CODE 8'hf0
`define FPSQ_RESP_OKAY 2'h0
`define FPSQ_RESP_DECERR 2'h3
`endif

/* File: sim/fpsq_ctrl_bench.sv */
// self-checking bench for the flash sequencer controller
`timescale 1ns/100ps
`include "fpsq_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module fpsq_ctrl_bench;
    typedef struct {string nm; logic [33:0] e; logic [33:0] m;} fpsq_note_type;
    logic aclk, aresetn, awv, wv, bready, arv, rready, bad, unp;
    logic awr, wr_r, bvalid, arr, rvalid;
    logic [7:0] awa, ara, dq_i;
    logic [31:0] wd, rdata, got;
    logic [1:0] bresp, rresp;
    logic [18:0] pa, pc;
    logic [7:0] pv, pw;
    fpsq_pkg::fpsq_pins_type pins;
    fpsq_note_type q[$];
    fpsq_note_type t;
    int bad_count = 0;
    int n_checks = 0;
    fpsq_ctrl u_fpsq_ctrl (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dq_i(dq_i),
        .pins(pins));
    fpsq_dev_model u_fpsq_dev_model (.aclk(aclk), .pins(pins), .bad(bad),
        .unprot(unp), .dq_i(dq_i));
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk)
        if (bvalid === 1'b1 && bready || rvalid === 1'b1 && rready) begin
            t = q.pop_front();
            if (t.m != 0)
                `CHK(t.nm, t.e & t.m, (bvalid ? {bresp, 32'h0}
                    : {rresp, rdata}) & t.m)
        end
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt,
        input logic [1:0] rs);
        q.push_back('{"bresp", {rs, 32'h0}, 34'h3_0000_0000});
        @(posedge aclk);
        awa <= ad;
        wd <= dt;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr)
                awv <= 1'b0;
            if (wr_r)
                wv <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [33:0] e, m,
        input string nm);
        q.push_back('{nm, e, m});
        @(posedge aclk);
        ara <= ad;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr)
                arv <= 1'b0;
        end while (rvalid !== 1'b1);
        got = rdata;
        rready <= 1'b0;
    endtask
    // one command with its operands, plus a bulk erase command written while a program runs, then status polling until idle
    task automatic run(input logic [3:0] c, input logic [18:0] ad,
        input logic [7:0] dt);
        wr(`FPSQ_OFS_ADDR, {13'h0, ad}, `FPSQ_RESP_OKAY);
        wr(`FPSQ_OFS_WDATA, {24'h0, dt}, `FPSQ_RESP_OKAY);
        wr(`FPSQ_OFS_CMD, {28'h0, c}, `FPSQ_RESP_OKAY);
        if (c == 4'd1)
            wr(`FPSQ_OFS_CMD, 32'h2, `FPSQ_RESP_OKAY);
        got = 32'h1;
        for (int i = 0; i < 6000 && got[0] !== 1'b0; i++)
            rd(`FPSQ_OFS_STATUS, 34'h0, 34'h0, "poll");
        // a poll limit that runs out counts as a mismatch
        if (got[0] !== 1'b0)
            bad_count++;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge aclk);
        bad_count++;
        give_verdict;
    end
    initial begin
        {aresetn, awv, wv, bready, arv, rready, bad, unp} = '0;
        {awa, ara, wd} = '0;
        void'($urandom(96273));
        pa = {3'($urandom_range(1)), 16'($urandom)};
        pc = {3'd4, 16'($urandom)};
        pv = 8'($urandom);
        pw = 8'($urandom);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(`FPSQ_OFS_STATUS, 34'h0, 34'h7, "status idle");
        rd(8'h14, {`FPSQ_RESP_DECERR, 32'h0}, '1, "unmapped");
        wr(`FPSQ_OFS_STATUS, 32'h1, `FPSQ_RESP_DECERR);
        $display("test registers done");
        run(4'd1, pa, pv);
        rd(`FPSQ_OFS_STATUS, 34'h2, 34'h7, "prog done");
        rd(`FPSQ_OFS_RDATA, {26'h0, pv}, 34'hff, "final read");
        run(4'd1, pc, pw);
        run(4'd1, {3'd7, 16'h0}, 8'h00);
        run(4'd0, {3'd7, 16'h0}, 8'h00);
        rd(`FPSQ_OFS_RDATA, 34'hff, 34'hff, "protected");
        $display("test program done");
        bad <= 1'b1;
        run(4'd1, pc + 19'h1, 8'h00);
        rd(`FPSQ_OFS_STATUS, 34'h4, 34'h5, "fail");
        bad <= 1'b0;
        $display("test failure done");
        run(4'd3, pa, 8'h00);
        run(4'd7, 19'h0, 8'h00);
        run(4'd0, pa, 8'h00);
        rd(`FPSQ_OFS_RDATA, {26'h0, pv}, 34'hff, "cancel");
        run(4'd3, {3'd0, 16'h0}, 8'h00);
        run(4'd4, {3'd1, 16'h0}, 8'h00);
        run(4'd5, 19'h0, 8'h00);
        run(4'd0, pc, 8'h00);
        rd(`FPSQ_OFS_RDATA, {26'h0, pw}, 34'hff, "suspended");
        run(4'd6, 19'h0, 8'h00);
        run(4'd8, pa, 8'h00);
        rd(`FPSQ_OFS_RDATA, 34'hff, 34'hff, "erased");
        rd(`FPSQ_OFS_STATUS, 34'h8, 34'h8, "window");
        $display("test sector erase done");
        run(4'd2, pc, 8'h00);
        rd(`FPSQ_OFS_RDATA, 34'hff, 34'hff, "bulk");
        $display("test bulk erase done");
        unp <= 1'b1;
        @(posedge aclk);
        unp <= 1'b0;
        run(4'd1, {3'd7, 16'h0}, pv);
        rd(`FPSQ_OFS_RDATA, {26'h0, pv}, 34'hff, "unprotected");
        $display("test unprotect done");
        give_verdict;
    end
endmodule // fpsq_ctrl_bench

/* File: sim/fpsq_dev_model.sv */
// behavioural flash device answering the controller pins
`timescale 1ns/100ps
`include "fpsq_regs.svh"
module fpsq_dev_model #(
    parameter int PCYC = 300,
    parameter int WCYC = 2000
) (
    input wire logic aclk,
    input wire fpsq_pkg::fpsq_pins_type pins,
    input wire logic bad,
    input wire logic unprot,
    output logic [7:0] dq_i
);
    logic [7:0] mem [0:255];
    logic [7:0] pd, pi, lq, rv, st, sm, ix, d, pr;
    logic [2:0] sq, md;
    logic [15:0] n;
    logic tg, fl, wq, oq, wr;
    logic [18:0] a;
    assign a = pins.addr;
    assign d = pins.dq_o;
    assign ix = {a[18:16], a[4:0]};
    assign wr = !wq && pins.we_n && !pins.en_n;
    always_comb begin
        st = {1'b0, tg, fl, 1'b0, md != 3'd3, 3'b0};
        if (md == 3'd1)
            st[7] = ~pd[7];
        // erased sectors read garbage while suspended
        rv = md inside {[3'd1:3'd5]} ? st
            : sm[a[18:16]] ? ~mem[ix] : mem[ix];
    end
    // released bus shows the inverse, not a stale value
    assign dq_i = pins.dq_oe ? d
        : !pins.en_n && !pins.oe_n ? rv : ~lq;
    initial begin
        foreach (mem[i])
            mem[i] = 8'hff;
        {pd, pi, lq, sm, sq, md, n, tg, fl, wq, oq} = '0;
        // only the top sector starts protected
        pr = 8'h80;
    end
    always @(posedge aclk) begin
        wq <= pins.we_n;
        oq <= pins.oe_n;
        if (unprot)
            pr <= 8'h00;
        if (!pins.en_n && !pins.oe_n)
            lq <= rv;
        if (oq && !pins.oe_n && !pins.en_n && md inside {[3'd1:3'd5]})
            tg <= ~tg;
        if (n > 1 && !fl)
            n <= n - 16'd1;
        if (n == 1) begin
            n <= md == 3'd3 ? 16'(2 * WCYC) : 16'd0;
            md <= md == 3'd3 ? 3'd4 : md == 3'd5 ? 3'd6 : 3'd0;
            if (md == 3'd1)
                mem[pi] <= pd;
            foreach (mem[i])
                if ((md == 3'd2 || md == 3'd4 && sm[i / 32]) && !pr[i / 32])
                    mem[i] <= 8'hff;
            if (md == 3'd4)
                sm <= '0;
        end
        if (wr) begin
            sq <= '0;
            if (d == `FPSQ_RESET_CODE && (md != 3'd1 || fl) && md != 3'd2)
                {md, n, fl, sm} <= '0;
            else if (md == 3'd3) begin
                if (d == `FPSQ_SECT_CONFIRM) begin
                    sm[a[18:16]] <= 1'b1;
                    n <= 16'(WCYC);
                end else if (d == `FPSQ_SUSPEND_CODE) begin
                    md <= 3'd5;
                    n <= 16'd50;
                end else
                    {md, n, sm} <= '0;
            end else if (md == 3'd4 && d == `FPSQ_SUSPEND_CODE) begin
                md <= 3'd5;
                n <= 16'd50;
            end else if (md == 3'd6 && d == `FPSQ_RESUME_CODE) begin
                md <= 3'd4;
                n <= 16'(WCYC);
            end else if (md == 3'd0)
                case (sq)
                    3'd0, 3'd4: if (a == `FPSQ_UNLK_ADDR1
                        && d == `FPSQ_UNLK_DATA1) sq <= sq + 3'd1;
                    3'd1, 3'd5: if (a == `FPSQ_UNLK_ADDR2
                        && d == `FPSQ_UNLK_DATA2) sq <= sq + 3'd1;
                    3'd2: if (a == `FPSQ_UNLK_ADDR1)
                        sq <= d == `FPSQ_PROG_CODE ? 3'd3
                            : d == `FPSQ_ERASE_SETUP ? 3'd4 : 3'd0;
                    3'd3: if (!pr[a[18:16]]) begin
                        md <= 3'd1;
                        {pd, pi, fl} <= {d, ix, bad};
                        n <= 16'(PCYC);
                    end
                    3'd6: if (d == `FPSQ_SECT_CONFIRM) begin
                        md <= 3'd3;
                        sm[a[18:16]] <= 1'b1;
                        n <= 16'(WCYC);
                    end else if (a == `FPSQ_UNLK_ADDR1
                        && d == `FPSQ_BULK_CONFIRM) begin
                        md <= 3'd2;
                        n <= 16'(4 * PCYC);
                    end
                    default: sq <= '0;
                endcase
        end
    end
endmodule // fpsq_dev_model
